// File: dim_pkg.sv
// Purpose: constants for the drive input function mapper
// Assumes: 20 MHz control clock, eight input terminals
// Notes:   function codes are per terminal; see per-terminal localparam groups
`default_nettype none
package dim_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned DEB_TIME_US     = 1000;
    localparam int unsigned DEB_CYCLES      = (CLK_HZ / 1_000_000) * DEB_TIME_US;
    localparam int unsigned DEB_W           = 15;
    localparam int unsigned NUM_TERM        = 8;
    localparam int unsigned CODE_W          = 5;

    // Terminal indices (terminal 16,17,18,19,27,29,32,33)
    localparam int unsigned T16 = 0;
    localparam int unsigned T17 = 1;
    localparam int unsigned T18 = 2;
    localparam int unsigned T19 = 3;
    localparam int unsigned T27 = 4;
    localparam int unsigned T29 = 5;
    localparam int unsigned T32 = 6;
    localparam int unsigned T33 = 7;

    // Common codes
    localparam logic [4:0] FN_UNUSED_INPUT      = 5'h00;
    localparam logic [4:0] FN_RESET             = 5'h01;
    localparam logic [4:0] FN_FREEZE_REF        = 5'h02;
    // Terminal 18
    localparam logic [4:0] FN18_START           = 5'h01;
    // Terminal 19
    localparam logic [4:0] FN19_REVERSE         = 5'h01;
    localparam logic [4:0] FN19_START_REVERSE   = 5'h02;
    localparam logic [4:0] FN19_DC_BRAKE_LOW    = 5'h03;
    // Terminal 27
    localparam logic [4:0] FN27_COAST_LOW       = 5'h00;
    localparam logic [4:0] FN27_COAST_CLEAR_LOW = 5'h01;
    localparam logic [4:0] FN27_DC_BRAKE_LOW    = 5'h02;
    localparam logic [4:0] FN27_GUARD_INTERLOCK = 5'h03;
    // Setup select and misc per terminal
    localparam logic [4:0] FN_SETUP_LSB_A       = 5'h04;
    localparam logic [4:0] FN_SETUP_MSB_A       = 5'h04;
    localparam logic [4:0] FN29_SETUP_MSB       = 5'h05;
    localparam logic [4:0] FN29_JOG             = 5'h0C;
    localparam logic [4:0] FN_JOG               = 5'h09;
    localparam logic [4:0] FN_EMERG_RUN         = 5'h0D;
    localparam logic [4:0] FN_EMERG_RUN_LOW     = 5'h0E;
    localparam logic [4:0] FN_CAL_RUN_EN        = 5'h19;

    // Highest legal code per terminal
    localparam logic [4:0] MAX_CODE [NUM_TERM] = '{5'h19, 5'h19, 5'h01, 5'h03,
                                                    5'h03, 5'h10, 5'h0C, 5'h0D};
    // Factory defaults
    localparam logic [4:0] DEF_CODE [NUM_TERM] = '{FN_RESET, FN_FREEZE_REF, FN18_START, FN19_REVERSE,
                                                    FN27_COAST_LOW, FN29_JOG, FN_UNUSED_INPUT, FN_UNUSED_INPUT};

    localparam logic [1:0] SETUP_ONE = 2'h0;
endpackage
`default_nettype wire

// File: dim_debounce.sv
// Purpose: two-flop synchroniser plus debounce for one terminal
// Assumes: input asynchronous to i_core_clk
// Notes:   output changes only after DEB_CYCLES of stable input
`default_nettype none
module dim_debounce (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    // Pin and result
    input  wire logic i_pin,
    output logic      o_level
);
    typedef struct packed {
        logic                         s1;
        logic                         s2;
        logic                         lvl;
        logic [dim_pkg::DEB_W-1:0]    cnt;
    } dim_deb_t;

    dim_deb_t st_q;
    dim_deb_t st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = i_pin;
        st_d.s2 = st_q.s1;
        if (st_q.s2 == st_q.lvl) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == dim_pkg::DEB_W'(dim_pkg::DEB_CYCLES - 1)) begin
            st_d.lvl = st_q.s2;
            st_d.cnt = '0;
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            // Start at the idle high level so release gives no false low or edge
            st_q     <= '0;
            st_q.s1  <= 1'b1;
            st_q.s2  <= 1'b1;
            st_q.lvl <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.lvl;

    a_deb_stable: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $changed(st_q.lvl) |-> $past(st_q.s2) == st_q.lvl)
        else $error("debounced level changed without stable input");
endmodule
`default_nettype wire

// File: dim_mapper.sv
// Purpose: maps eight digital input terminals to drive commands and alarms
// Assumes: terminal order 16,17,18,19,27,29,32,33; 20 MHz clock
// Notes:   selections are registered from i_sel_code on i_sel_load; codes above MAX_CODE are ignored
`default_nettype none
module dim_mapper (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    // Terminal pins
    input  wire logic [7:0]  i_term_pin,
    // Selections
    input  wire logic        i_sel_load,
    input  wire logic [39:0] i_sel_code,
    output logic      [39:0] o_sel_code,
    // Drive configuration
    input  wire logic        i_brake_cur_nz,
    input  wire logic        i_brake_time_nz,
    input  wire logic        i_multi_setup,
    input  wire logic        i_halt_key,
    input  wire logic        i_alarm_pending,
    input  wire logic [3:0]  i_out_sel_interlock,
    // Commands
    output logic             o_coast,
    output logic             o_dc_brake,
    output logic             o_run,
    output logic             o_reverse,
    output logic             o_freeze_ref,
    output logic             o_jog,
    output logic             o_alarm_clear,
    output logic             o_ext_fault,
    output logic [3:0]       o_out_fault,
    output logic [1:0]       o_setup,
    output logic             o_emerg_run,
    output logic             o_cal_run_en
);
    typedef struct packed {
        logic [39:0] sel;
        logic [7:0]  prev;
        logic        coast;
        logic        brake;
        logic        run;
        logic        rev;
        logic        frz;
        logic        jog;
        logic        clr;
        logic        fault;
        logic [3:0]  out_fault;
        logic [1:0]  setup;
        logic        emerg;
        logic        cal;
    } dim_state_t;

    dim_state_t st_q;
    dim_state_t st_d;
    logic [7:0] lvl;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [4:0] code [8];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_term
            dim_debounce u_deb (
                .i_core_clk (i_core_clk),
                .i_sys_rst  (i_sys_rst),
                .i_pin      (i_term_pin[gi]),
                .o_level    (lvl[gi])
            );
            assign code[gi] = st_q.sel[gi*5 +: 5];
            assign rise[gi] = lvl[gi] & ~st_q.prev[gi];
            assign fall[gi] = ~lvl[gi] & st_q.prev[gi];
        end
    endgenerate

    always_comb begin
        logic       any_reset;
        logic       lsb;
        logic       msb;
        logic [4:0] nc;
        any_reset = 1'b0;
        lsb       = 1'b0;
        msb       = 1'b0;
        nc        = '0;
        st_d      = st_q;
        st_d.prev = lvl;
        if (i_sel_load) begin
            for (int t = 0; t < 8; t++) begin
                nc = i_sel_code[t*5 +: 5];
                if (nc <= dim_pkg::MAX_CODE[t]) begin
                    st_d.sel[t*5 +: 5] = nc;
                end
            end
        end
        for (int t = 0; t < 8; t++) begin
            // Unused code matches no branch, so the pin is ignored
            if (code[t] == dim_pkg::FN_RESET && t != dim_pkg::T18 && t != dim_pkg::T19
                && t != dim_pkg::T27 && rise[t]) begin
                any_reset = 1'b1;
            end
        end
        st_d.coast = 1'b0;
        st_d.brake = 1'b0;
        unique case (code[dim_pkg::T27])
            dim_pkg::FN27_COAST_LOW: st_d.coast = ~lvl[dim_pkg::T27];
            dim_pkg::FN27_COAST_CLEAR_LOW: begin
                st_d.coast = ~lvl[dim_pkg::T27];
                if (fall[dim_pkg::T27]) begin
                    any_reset = 1'b1;
                end
            end
            dim_pkg::FN27_DC_BRAKE_LOW: st_d.brake = ~lvl[dim_pkg::T27];
            dim_pkg::FN27_GUARD_INTERLOCK: st_d.coast = ~lvl[dim_pkg::T27];
            default: st_d.coast = 1'b0;
        endcase
        if (code[dim_pkg::T19] == dim_pkg::FN19_DC_BRAKE_LOW && !lvl[dim_pkg::T19]) begin
            st_d.brake = 1'b1;
        end
        st_d.brake = st_d.brake & i_brake_cur_nz & i_brake_time_nz;
        st_d.clr = any_reset | (i_halt_key & st_q.fault);
        // Set wins over clear: fault stays while interlock input is low
        if (code[dim_pkg::T27] == dim_pkg::FN27_GUARD_INTERLOCK && !lvl[dim_pkg::T27]) begin
            st_d.fault = 1'b1;
        end else if (any_reset || i_halt_key) begin
            st_d.fault = 1'b0;
        end
        st_d.out_fault = i_out_sel_interlock & {4{st_d.fault}};
        st_d.run = (code[dim_pkg::T18] == dim_pkg::FN18_START) & lvl[dim_pkg::T18];
        st_d.rev = 1'b0;
        if (code[dim_pkg::T19] == dim_pkg::FN19_REVERSE) begin
            st_d.rev = lvl[dim_pkg::T19];
        end else if (code[dim_pkg::T19] == dim_pkg::FN19_START_REVERSE) begin
            st_d.rev = lvl[dim_pkg::T19];
            st_d.run = lvl[dim_pkg::T19];
        end
        st_d.frz = 1'b0;
        st_d.jog = 1'b0;
        for (int t = 0; t < 8; t++) begin
            if (t == dim_pkg::T16 || t == dim_pkg::T17 || t == dim_pkg::T29
                || t == dim_pkg::T32 || t == dim_pkg::T33) begin
                if (code[t] == dim_pkg::FN_FREEZE_REF && lvl[t]) begin
                    st_d.frz = 1'b1;
                end
            end
        end
        if ((code[dim_pkg::T29] == dim_pkg::FN29_JOG && lvl[dim_pkg::T29])
            || (code[dim_pkg::T16] == dim_pkg::FN_JOG && lvl[dim_pkg::T16])
            || (code[dim_pkg::T17] == dim_pkg::FN_JOG && lvl[dim_pkg::T17])
            || (code[dim_pkg::T32] == dim_pkg::FN_JOG && lvl[dim_pkg::T32])
            || (code[dim_pkg::T33] == dim_pkg::FN_JOG && lvl[dim_pkg::T33])) begin
            st_d.jog = 1'b1;
        end
        lsb = (code[dim_pkg::T16] == dim_pkg::FN_SETUP_LSB_A && lvl[dim_pkg::T16])
            | (code[dim_pkg::T29] == dim_pkg::FN_SETUP_LSB_A && lvl[dim_pkg::T29])
            | (code[dim_pkg::T32] == dim_pkg::FN_SETUP_LSB_A && lvl[dim_pkg::T32]);
        msb = (code[dim_pkg::T17] == dim_pkg::FN_SETUP_MSB_A && lvl[dim_pkg::T17])
            | (code[dim_pkg::T29] == dim_pkg::FN29_SETUP_MSB && lvl[dim_pkg::T29])
            | (code[dim_pkg::T33] == dim_pkg::FN_SETUP_MSB_A && lvl[dim_pkg::T33]);
        st_d.setup = i_multi_setup ? {msb, lsb} : dim_pkg::SETUP_ONE;
        st_d.emerg = (code[dim_pkg::T16] == dim_pkg::FN_EMERG_RUN && lvl[dim_pkg::T16])
                   | (code[dim_pkg::T16] == dim_pkg::FN_EMERG_RUN_LOW && !lvl[dim_pkg::T16]);
        st_d.cal = (code[dim_pkg::T16] == dim_pkg::FN_CAL_RUN_EN && lvl[dim_pkg::T16])
                 | (code[dim_pkg::T17] == dim_pkg::FN_CAL_RUN_EN && lvl[dim_pkg::T17]);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q      <= '0;
            st_q.sel  <= {dim_pkg::DEF_CODE[7], dim_pkg::DEF_CODE[6], dim_pkg::DEF_CODE[5],
                          dim_pkg::DEF_CODE[4], dim_pkg::DEF_CODE[3], dim_pkg::DEF_CODE[2],
                          dim_pkg::DEF_CODE[1], dim_pkg::DEF_CODE[0]};
            st_q.prev <= 8'hFF;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sel_code    = st_q.sel;
    assign o_coast       = st_q.coast;
    assign o_dc_brake    = st_q.brake;
    assign o_run         = st_q.run;
    assign o_reverse     = st_q.rev;
    assign o_freeze_ref  = st_q.frz;
    assign o_jog         = st_q.jog;
    assign o_alarm_clear = st_q.clr & i_alarm_pending;
    assign o_ext_fault   = st_q.fault;
    assign o_out_fault   = st_q.out_fault;
    assign o_setup       = st_q.setup;
    assign o_emerg_run   = st_q.emerg;
    assign o_cal_run_en  = st_q.cal;

    a_coast_low: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[4] == 5'h00 && !lvl[4]) |=> o_coast)
        else $error("coast not applied on low");
    a_reset_rise: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[0] == 5'h01 && rise[0]) |=> st_q.clr)
        else $error("reset edge missed");
    a_reset_level: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[0] == 5'h01 && lvl[0] && !rise[0] && code[4] != 5'h01 && !i_halt_key
         && (code[1] != 5'h01) && (code[5] != 5'h01) && (code[6] != 5'h01) && (code[7] != 5'h01))
        |=> !st_q.clr)
        else $error("reset on static level");
    a_clear_fall: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[4] == 5'h01 && fall[4]) |=> (st_q.clr && o_coast))
        else $error("coast and clear failed");
    a_brake_gate: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !(i_brake_cur_nz && i_brake_time_nz) |=> !o_dc_brake)
        else $error("brake without current and time");
    a_brake_low: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[4] == 5'h02 && !lvl[4] && i_brake_cur_nz && i_brake_time_nz) |=> o_dc_brake)
        else $error("brake not applied");
    a_guard_fault: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[4] == 5'h03 && !lvl[4]) |=> (o_coast && o_ext_fault))
        else $error("interlock did not fault");
    a_fault_out: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        o_out_fault == (i_out_sel_interlock & {4{o_ext_fault}}) || $changed(i_out_sel_interlock))
        else $error("fault outputs mismatch");
    a_halt_clear: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_halt_key && !(code[4] == 5'h03 && !lvl[4])) |=> !o_ext_fault)
        else $error("halt key did not clear fault");
    a_run_level: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[2] == 5'h01 && code[3] != 5'h02) |=> o_run == $past(lvl[2]))
        else $error("run does not follow start");
    a_rev_nostart: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[3] == 5'h01 && code[2] == 5'h00) |=> (!o_run && o_reverse == $past(lvl[3])))
        else $error("reverse issued start");
    a_setup_single: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !i_multi_setup |=> o_setup == 2'h0)
        else $error("setup changed without multi setup");
    a_unused_quiet: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (code[6] == 5'h00 && code[7] == 5'h00 && code[0] == 5'h00 && code[1] == 5'h00
         && code[5] == 5'h00 && code[4] == 5'h00 && !i_halt_key) |=> !st_q.clr)
        else $error("unused terminal acted");
    a_code_legal: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        code[2] <= 5'h01 && code[3] <= 5'h03 && code[4] <= 5'h03)
        else $error("illegal code stored");
    a_reset_dflt: assert property (@(posedge i_core_clk)
        ($past(i_sys_rst) && !i_sys_rst) |-> (code[2] == 5'h01 && code[6] == 5'h00))
        else $error("defaults not loaded");
endmodule
`default_nettype wire

// File: dim_switches.sv
// Purpose: behavioural model of the switches wired to the eight input terminals
// Assumes: one target level per terminal, set by the bench
// Notes:   optional contact chatter toggles the changed bits before they settle
`default_nettype none
module dim_switches (
    // Clock
    input  wire logic       i_core_clk,
    // Commanded levels
    input  wire logic [7:0] i_target,
    input  wire logic       i_bounce,
    // Terminal levels
    output logic      [7:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pin_q     = 8'hFF;
    logic [7:0] last_q    = 8'hFF;
    logic [7:0] diff_q    = 8'h00;
    logic [3:0] chatter_q = 4'h0;
    assign o_pin = pin_q;
    // Slow contacts chatter for nine cycles; a fast one switches cleanly
    always @(posedge i_core_clk) begin
        if (i_target !== last_q) begin
            chatter_q <= i_bounce ? 4'h9 : 4'h0;
            diff_q    <= i_target ^ last_q;
            last_q    <= i_target;
            pin_q     <= i_bounce ? (pin_q ^ (i_target ^ last_q)) : i_target;
        end else if (chatter_q != 4'h0) begin
            chatter_q <= chatter_q - 4'h1;
            pin_q     <= (chatter_q == 4'h1) ? last_q : (pin_q ^ diff_q);
        end
    end
endmodule
`default_nettype wire

// File: dim_mapper_bench.sv
// Purpose: self-checking bench for the input function mapper
// Assumes: debounce fixed at DEB_CYCLES, so each pin phase takes about 20000 cycles
// Notes:   drivers queue expectations; a watcher process compares them
`default_nettype none
module dim_mapper_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY    = 5;
    localparam int SETTLE = dim_pkg::DEB_CYCLES + 20;
    localparam int LIMIT  = 100000;
    typedef struct {string name; int sel; logic [39:0] exp;} dim_note_t;
    dim_note_t  notes[$];
    event       sample_ev;
    int         miscompares = 0;
    int         checks_done = 0;
    int         pulses      = 0;
    int         cycles      = 0;
    logic [31:0] lfsr_q     = 32'h7953C326;
    logic [4:0] cfg [8];
    logic core_clk = 1'b0, sys_rst = 1'b1, sel_load = 1'b0, bounce = 1'b0;
    logic brake_cur = 1'b1, brake_time = 1'b1, multi = 1'b1, halt = 1'b0, pend = 1'b1;
    logic [7:0] target = 8'hFF, pins;
    logic [39:0] sel_code = 40'h0, sel_seen;
    logic [3:0] ilk_sel = 4'h0, out_fault;
    logic [1:0] setup;
    logic coast, dc_brake, run, reverse, freeze, jog, alarm_clear, ext_fault, emerg, cal_en;

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    dim_switches partner (.i_core_clk(core_clk), .i_target(target), .i_bounce(bounce), .o_pin(pins));

    dim_mapper DUT (
        .i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_term_pin(pins), .i_sel_load(sel_load),
        .i_sel_code(sel_code), .o_sel_code(sel_seen), .i_brake_cur_nz(brake_cur),
        .i_brake_time_nz(brake_time), .i_multi_setup(multi), .i_halt_key(halt),
        .i_alarm_pending(pend), .i_out_sel_interlock(ilk_sel), .o_coast(coast), .o_dc_brake(dc_brake),
        .o_run(run), .o_reverse(reverse), .o_freeze_ref(freeze), .o_jog(jog),
        .o_alarm_clear(alarm_clear), .o_ext_fault(ext_fault), .o_out_fault(out_fault), .o_setup(setup),
        .o_emerg_run(emerg), .o_cal_run_en(cal_en));

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [39:0] seen_of(input int sel);
        case (sel)
            0: return sel_seen;
            1: return {39'h0, coast};
            2: return {39'h0, dc_brake};
            3: return {39'h0, run};
            4: return {39'h0, reverse};
            5: return {39'h0, ext_fault};
            6: return {36'h0, out_fault};
            7: return {38'h0, setup};
            8: return 40'(pulses);
            10: return {39'h0, freeze};
            11: return {39'h0, jog};
            12: return {39'h0, emerg};
            default: return {39'h0, cal_en};
        endcase
    endfunction

    function automatic logic [39:0] pack_cfg();
        logic [39:0] v;
        v = 40'h0;
        for (int t = 0; t < 8; t++) v[5*t +: 5] = cfg[t];
        return v;
    endfunction

    task automatic note(input string name, input int sel, input logic [39:0] exp);
        dim_note_t n;
        n = '{name, sel, exp};
        notes.push_back(n);
        -> sample_ev;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #DLY;
    endtask

    task automatic load();
        sel_code = pack_cfg();
        sel_load = 1'b1;
        step(1);
        sel_load = 1'b0;
        step(1);
    endtask

    // Watcher: every result taken against the oldest note
    initial begin
        dim_note_t n;
        forever begin
            @(sample_ev);
            while (notes.size() > 0) begin
                n = notes.pop_front();
                check(n.name, seen_of(n.sel), n.exp);
            end
        end
    end

    always @(posedge core_clk) begin
        if (alarm_clear === 1'b1) pulses++;
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        step(4);
        sys_rst = 1'b0;
        step(2);
        cfg = '{5'h01, 5'h02, 5'h01, 5'h01, 5'h00, 5'h0C, 5'h00, 5'h00};
        note("sel_defaults", 0, pack_cfg());
        cfg = '{5'h01, 5'h04, 5'h01, 5'h03, 5'h03, 5'h04, 5'h00, 5'h01};
        load();
        note("sel_legal", 0, pack_cfg());
        cfg[0] = 5'h19;
        cfg[2] = 5'h02;
        cfg[4] = 5'h09;
        load();
        cfg[2] = 5'h01;
        cfg[4] = 5'h03;
        note("sel_illegal", 0, pack_cfg());
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        ilk_sel = lfsr_q[3:0] | 4'h1;
        step(SETTLE);
        note("run_high", 3, 40'h1);
        note("coast_high", 1, 40'h0);
        note("brake_high", 2, 40'h0);
        note("setup_three", 7, 40'h3);
        note("cal_enable", 9, 40'h1);
        note("no_freeze", 10, 40'h0);
        note("no_jog", 11, 40'h0);
        note("no_emerg", 12, 40'h0);
        // Phase 1: interlock, stop, brake, setup lsb low; unused pin random
        cfg[0] = 5'h01;
        load();
        pulses = 0;
        bounce = 1'b1;
        target = {1'b1, lfsr_q[9], 6'b000010};
        step(SETTLE);
        note("ilk_coast", 1, 40'h1);
        note("ilk_fault", 5, 40'h1);
        note("out_fault", 6, {36'h0, ilk_sel});
        note("run_low", 3, 40'h0);
        note("brake_low", 2, 40'h1);
        note("setup_two", 7, 40'h2);
        note("no_fall_clear", 8, 40'h0);
        brake_time = 1'b0;
        step(3);
        note("brake_gated", 2, 40'h0);
        multi = 1'b0;
        step(3);
        note("setup_single", 7, {38'h0, dim_pkg::SETUP_ONE});
        halt = 1'b1;
        step(2);
        halt = 1'b0;
        step(2);
        note("fault_held", 5, 40'h1);
        cfg[4] = 5'h00;
        load();
        halt = 1'b1;
        step(2);
        halt = 1'b0;
        step(2);
        note("halt_clear", 5, 40'h0);
        note("coast_low", 1, 40'h1);
        cfg[4] = 5'h03;
        load();
        step(2);
        note("fault_again", 5, 40'h1);
        cfg[4] = 5'h00;
        load();
        // Phase 2: reset terminal rises, coast pin released
        pulses = 0;
        target = target | 8'h11;
        step(SETTLE);
        note("rise_clear", 8, 40'h1);
        note("term_clear", 5, 40'h0);
        note("coast_off", 1, 40'h0);
        // Phase 3: coast-and-clear falls, reversing raised without start
        cfg[4] = 5'h01;
        cfg[3] = 5'h01;
        load();
        pulses = 0;
        bounce = 1'b0;
        target = (target & 8'hEF) | 8'h08;
        step(SETTLE);
        note("cc_coast", 1, 40'h1);
        note("cc_clear", 8, 40'h1);
        note("reverse_on", 4, 40'h1);
        note("no_self_start", 3, 40'h0);
        step(2);
        summarize();
    end
endmodule
`default_nettype wire
